// ---- frp_pkg.sv ----
// Package: constants and carrier types for the flash rewrite protection block
package frp_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [19:0] DATA_FLASH_CONTROL_ADDR = 20'hf_0090;
  localparam logic [7:0] DATA_FLASH_CONTROL_RST = 8'h00;
  localparam int ACCESS_ENABLE_BIT = 0;
  // ****************************************
  // Flash geometry
  // ****************************************
  localparam logic [19:0] BOOT0_LAST_ADDR = 20'h0_0fff;
  localparam int CODE_BLOCK_SHIFT = 10;
  localparam int DATA_BLOCK_BYTES = 1024;
  localparam logic [19:0] DATA_FLASH_BASE = 20'hf_1000;
  localparam logic [19:0] DATA_FLASH_LAST = 20'hf_17ff;
  localparam logic [7:0] BLOCK_NONE = 8'h00;
  localparam logic [7:0] BLOCK_ALL = 8'hff;
  // ****************************************
  // Setup timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETUP_FAST_NS = 5000;
  localparam int SETUP_SLOW_NS = 720;
  localparam int SETUP_FAST_CYC = (SETUP_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_SLOW_CYC = (SETUP_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CNT_W = 11;

  typedef enum logic [1:0] {
    FRP_OP_ERASE = 2'b01,
    FRP_OP_WRITE = 2'b10
  } frp_op_t;

  // Rewrite request from programmer or CPU library
  typedef struct packed {
    logic valid;
    logic serial;
    frp_op_t op;
    logic [19:0] addr;
  } frp_req_t;

  // Security settings
  typedef struct packed {
    logic erase_prohibit;
    logic write_prohibit;
    logic boot0_prohibit;
  } frp_sec_t;
endpackage

// ---- frp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module frp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// ---- frp_setup_timer.sv ----
// Data flash setup timer started when access is enabled
`timescale 1ns/1ps
module frp_setup_timer (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_low_speed,
  output logic o_ready
);
  logic [frp_pkg::SETUP_CNT_W-1:0] cnt_q;
  logic enable_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      enable_q <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      enable_q <= i_enable;
      if (!i_enable) begin
        cnt_q <= '0;
        o_ready <= 1'b0;
      end else if (!enable_q) begin
        // Reload on the rising edge of enable
        cnt_q <= i_low_speed ? frp_pkg::SETUP_CNT_W'(frp_pkg::SETUP_SLOW_CYC - 1)
                             : frp_pkg::SETUP_CNT_W'(frp_pkg::SETUP_FAST_CYC - 1);
        o_ready <= 1'b0;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        o_ready <= 1'b1;
      end
    end
  end
endmodule

// ---- frp_core.sv ----
// Flash rewrite protection: window, security prohibitions and data flash gating
//
// Summary of operation
// - Self-programming rewrite outside the window range is refused.
// - Window start and end blocks are set only through serial programming.
// - Serial programming ignores the window.
// - Boot region prohibition beats the window.
// - Window checks only code flash; data flash never restricted by it.
// - Erase prohibition refuses serial erase; self erase still allowed.
// - Write prohibition refuses serial code writes; self writes still allowed.
// - Boot region prohibition refuses erase and write on both paths.
// - No prohibition after shipping; either path may set them.
// - The three prohibitions are independent bits.
// - Erase and boot prohibitions can never be cleared.
// - Write prohibition clears only if others clear and both areas blank.
// - Write prohibition clear becomes usable only after a reset.
// - Data flash erase acts on whole one-kilobyte blocks.
// - Data flash accesses are byte wide only.
// - Data flash readable as data, never fetchable as instructions.
// - Code fetch keeps running during background data flash rewrite.
// - Code flash self-rewrite blocks all data flash access.
// - Control register is frozen during data flash rewrite.
// - Deep-sleep entry is held off during data flash rewrite.
// - Data flash stays stopped after reset until access enable set.
// - Control register is eight bits, resets zero, only bit 0 writable.
// - Access enable 0 disables, 1 enables data flash.
// - Data flash unusable until setup time after enable.
`timescale 1ns/1ps
module frp_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Mode pins
  input wire logic i_serial_mode,
  input wire logic i_low_speed_main_mode,
  // Protection setting requests (single-cycle, same clock)
  input wire logic i_win_set,
  input wire logic i_win_set_serial,
  input wire logic [7:0] i_win_start,
  input wire logic [7:0] i_win_end,
  input wire logic i_sec_set,
  input frp_pkg::frp_sec_t i_sec_bits,
  input wire logic i_sec_release,
  input wire logic i_code_blank,
  input wire logic i_data_blank,
  // Rewrite request
  input frp_pkg::frp_req_t i_req,
  input wire logic i_flash_busy,
  // CPU data bus
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_fetch,
  input wire logic [19:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic i_cpu_bit_op,
  input wire logic [2:0] i_cpu_bit_pos,
  input wire logic [1:0] i_cpu_size,
  input wire logic i_stop_req,
  // Outputs
  output logic [7:0] o_cpu_rdata,
  output logic o_cpu_err,
  output logic o_flash_go,
  output frp_pkg::frp_req_t o_flash_cmd,
  output logic o_req_refused,
  output logic o_df_access_ok,
  output logic o_fetch_ok,
  output logic o_stop_grant,
  output frp_pkg::frp_sec_t o_sec,
  output logic [7:0] o_win_start,
  output logic [7:0] o_win_end
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic serial_s;
  logic low_speed_s;
  frp_sync #(.W(2)) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({i_serial_mode, i_low_speed_main_mode}),
    .o_q({serial_s, low_speed_s})
  );

  function automatic logic is_data_flash(input logic [19:0] a);
    is_data_flash = (a >= frp_pkg::DATA_FLASH_BASE) && (a <= frp_pkg::DATA_FLASH_LAST);
  endfunction

  // ****************************************
  // Window and security state
  // ****************************************
  logic [7:0] win_start_q;
  logic [7:0] win_end_q;
  // Shipped state: no prohibition at power-on
  frp_pkg::frp_sec_t sec_q = '0;
  logic release_armed_q;
  logic [7:0] ctl_q;
  logic df_rewrite_q;
  logic code_rewrite_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      win_start_q <= frp_pkg::BLOCK_NONE;
      win_end_q <= frp_pkg::BLOCK_ALL;
    end else if (i_win_set && i_win_set_serial) begin
      win_start_q <= i_win_start;
      win_end_q <= i_win_end;
    end
  end

  // Armed by reset only; a write prohibition set in this session disarms release until next reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      release_armed_q <= 1'b1;
    end else if (i_sec_set && i_sec_bits.write_prohibit) begin
      release_armed_q <= 1'b0;
    end
  end

  logic release_ok;
  assign release_ok = i_sec_release && release_armed_q && !sec_q.erase_prohibit &&
                      !sec_q.boot0_prohibit && i_code_blank && i_data_blank;

  // Security bits stand for flash-held settings: a reset must not clear them,
  // otherwise a reset would lift the permanent prohibitions
  always_ff @(posedge i_clk) begin
    // Erase and boot sets are sticky; independent bits
    sec_q.erase_prohibit <= sec_q.erase_prohibit | (i_sec_set & i_sec_bits.erase_prohibit);
    sec_q.boot0_prohibit <= sec_q.boot0_prohibit | (i_sec_set & i_sec_bits.boot0_prohibit);
    if (i_sec_set && i_sec_bits.write_prohibit) begin
      sec_q.write_prohibit <= 1'b1;
    end else if (release_ok) begin
      sec_q.write_prohibit <= 1'b0;
    end
  end

  // ****************************************
  // Rewrite request checking
  // ****************************************
  logic req_df;
  logic req_boot0;
  logic [7:0] req_block;
  logic in_window;
  logic refuse;
  logic req_serial;
  // The serial flag only counts inside a serial programming session
  assign req_serial = i_req.serial && serial_s;
  always_comb begin
    req_df = is_data_flash(i_req.addr);
    req_block = i_req.addr[17:10];
    req_boot0 = !req_df && (i_req.addr <= frp_pkg::BOOT0_LAST_ADDR);
    in_window = (req_block >= win_start_q) && (req_block <= win_end_q);
    refuse = 1'b0;
    if (!req_serial && !req_df && !in_window) begin
      refuse = 1'b1;
    end
    if (req_boot0 && sec_q.boot0_prohibit) begin
      refuse = 1'b1;
    end
    if (req_serial && i_req.op == frp_pkg::FRP_OP_ERASE && sec_q.erase_prohibit) begin
      refuse = 1'b1;
    end
    if (req_serial && i_req.op == frp_pkg::FRP_OP_WRITE && !req_df &&
        sec_q.write_prohibit) begin
      refuse = 1'b1;
    end
    if (req_df && !req_serial && !o_df_access_ok) begin
      refuse = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flash_go <= 1'b0;
      o_flash_cmd <= '0;
      o_req_refused <= 1'b0;
    end else begin
      o_flash_go <= i_req.valid && !refuse;
      o_req_refused <= i_req.valid && refuse;
      if (i_req.valid && !refuse) begin
        o_flash_cmd <= i_req;
        if (req_df && i_req.op == frp_pkg::FRP_OP_ERASE) begin
          // Align erase to a whole data block
          o_flash_cmd.addr <= {i_req.addr[19:10], 10'h000};
        end
      end
    end
  end

  // Busy tracking of background rewrites
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      df_rewrite_q <= 1'b0;
      code_rewrite_q <= 1'b0;
    end else if (i_req.valid && !refuse) begin
      df_rewrite_q <= req_df;
      code_rewrite_q <= !req_df && !req_serial;
    end else if (!i_flash_busy && !o_flash_go) begin
      df_rewrite_q <= 1'b0;
      code_rewrite_q <= 1'b0;
    end
  end

  // ****************************************
  // Data flash control register
  // ****************************************
  logic reg_hit;
  assign reg_hit = i_cpu_addr == frp_pkg::DATA_FLASH_CONTROL_ADDR;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_q <= frp_pkg::DATA_FLASH_CONTROL_RST;
    end else if (i_cpu_wr && reg_hit && !df_rewrite_q) begin
      if (i_cpu_bit_op) begin
        if (i_cpu_bit_pos == 3'h0) begin
          ctl_q[frp_pkg::ACCESS_ENABLE_BIT] <= i_cpu_wdata[0];
        end
      end else begin
        ctl_q <= {7'h00, i_cpu_wdata[frp_pkg::ACCESS_ENABLE_BIT]};
      end
    end
  end

  logic setup_ready;
  frp_setup_timer u_setup (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_enable(ctl_q[frp_pkg::ACCESS_ENABLE_BIT]),
    .i_low_speed(low_speed_s),
    .o_ready(setup_ready)
  );

  // ****************************************
  // CPU access gating
  // ****************************************
  logic cpu_df;
  assign cpu_df = is_data_flash(i_cpu_addr);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_df_access_ok <= 1'b0;
      o_fetch_ok <= 1'b0;
      o_stop_grant <= 1'b0;
      o_cpu_rdata <= 8'h00;
      o_cpu_err <= 1'b0;
    end else begin
      o_df_access_ok <= setup_ready && !code_rewrite_q;
      o_fetch_ok <= i_cpu_fetch && !cpu_df;
      o_stop_grant <= i_stop_req && !df_rewrite_q;
      o_cpu_rdata <= (i_cpu_rd && reg_hit) ? ctl_q : 8'h00;
      o_cpu_err <= (i_cpu_fetch && cpu_df) ||
                   ((i_cpu_rd || i_cpu_wr) && cpu_df &&
                    (i_cpu_size != 2'd0 || !o_df_access_ok));
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sec <= '0;
      o_win_start <= 8'h00;
      o_win_end <= 8'h00;
    end else begin
      o_sec <= sec_q;
      o_win_start <= win_start_q;
      o_win_end <= win_end_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_window_refuse: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_req.valid && !req_serial && !req_df && !in_window |=> !o_flash_go && o_req_refused)
    else $error("self rewrite outside window was not refused");
  a_serial_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_req.valid && req_serial && !req_df && !in_window && !sec_q.erase_prohibit &&
    !sec_q.write_prohibit && !sec_q.boot0_prohibit |=> o_flash_go)
    else $error("serial rewrite blocked by window");
  a_win_stable: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(i_win_set && i_win_set_serial) |=> $stable(win_start_q) && $stable(win_end_q))
    else $error("window changed outside serial path");
  a_boot_protect: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_req.valid && req_boot0 && sec_q.boot0_prohibit |=> !o_flash_go)
    else $error("boot region rewrite passed");
  a_erase_serial: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_req.valid && req_serial && i_req.op == frp_pkg::FRP_OP_ERASE &&
    sec_q.erase_prohibit |=> o_req_refused)
    else $error("serial erase passed while prohibited");
  a_sticky_sec: assert property (@(posedge i_clk) disable iff (!i_nrst)
    sec_q.erase_prohibit && sec_q.boot0_prohibit |=> sec_q.erase_prohibit &&
    sec_q.boot0_prohibit)
    else $error("permanent prohibition cleared");
  sequence s_wp_set;
    i_sec_set && i_sec_bits.write_prohibit;
  endsequence
  sequence s_release_try;
    i_sec_release [*1];
  endsequence
  a_release_after_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s_wp_set ##[1:4] s_release_try |=> sec_q.write_prohibit)
    else $error("write prohibition released without reset");
  a_ctl_frozen: assert property (@(posedge i_clk) disable iff (!i_nrst)
    df_rewrite_q |=> $stable(ctl_q))
    else $error("control register changed during data rewrite");
  a_stop_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    df_rewrite_q && i_stop_req |=> !o_stop_grant)
    else $error("stop granted during data rewrite");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ctl_q[7:1] == 7'h00)
    else $error("reserved control bits set");
  a_setup_wait: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(ctl_q[0]) && !low_speed_s |-> !o_df_access_ok [*8])
    else $error("data flash usable before setup time");
endmodule

// ---- frp_flash_model.sv ----
// Flash array model: stays busy for a fixed time after each accepted command
`timescale 1ns/1ps
module frp_flash_model #(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Command side
  input wire logic i_go,
  output logic o_busy
);
  int cnt_q;
  // A new command restarts the count, as a real array would refuse overlap
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 0;
    end else if (i_go) begin
      cnt_q <= BUSY_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign o_busy = (cnt_q != 0);
endmodule

// ---- tb_frp_core.sv ----
// Testbench for the flash rewrite protection core
`timescale 1ns/1ps
module tb_frp_core;
  localparam logic [19:0] CA = frp_pkg::DATA_FLASH_CONTROL_ADDR;
  localparam frp_pkg::frp_op_t OP_E = frp_pkg::FRP_OP_ERASE;
  localparam frp_pkg::frp_op_t OP_W = frp_pkg::FRP_OP_WRITE;
  logic clk, nrst, ser, slow, ws, wss, ss, rel, cb, db, busy, cwr, crd, cfe, bop, stp;
  logic [2:0] bp;
  logic [7:0] wst, wen, wd, rdata, owst, owen;
  logic [19:0] adr;
  logic [1:0] sz;
  logic err, go, refd, dfok, fok, sg;
  logic [8:0] v;
  frp_pkg::frp_sec_t sb, sec;
  frp_pkg::frp_req_t req, cmd;
  int checks, n_fail, cycles;

  frp_core frp_core_inst (.i_clk(clk), .i_nrst(nrst), .i_serial_mode(ser),
    .i_low_speed_main_mode(slow), .i_win_set(ws), .i_win_set_serial(wss),
    .i_win_start(wst), .i_win_end(wen), .i_sec_set(ss), .i_sec_bits(sb),
    .i_sec_release(rel), .i_code_blank(cb), .i_data_blank(db), .i_req(req),
    .i_flash_busy(busy), .i_cpu_wr(cwr), .i_cpu_rd(crd), .i_cpu_fetch(cfe),
    .i_cpu_addr(adr), .i_cpu_wdata(wd), .i_cpu_bit_op(bop), .i_cpu_bit_pos(bp),
    .i_cpu_size(sz), .i_stop_req(stp), .o_cpu_rdata(rdata), .o_cpu_err(err),
    .o_flash_go(go), .o_flash_cmd(cmd), .o_req_refused(refd), .o_df_access_ok(dfok),
    .o_fetch_ok(fok), .o_stop_grant(sg), .o_sec(sec), .o_win_start(owst),
    .o_win_end(owen));
  frp_flash_model frp_flash_model_inst (.i_clk(clk), .i_nrst(nrst), .i_go(go),
    .o_busy(busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cuts a hang short well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst();
    nrst = 1'b0;
    cyc(10);
    nrst = 1'b1;
    cyc(3);
  endtask
  task automatic mode(input logic s);
    ser = s;
    cyc(3);
  endtask
  // Expect {go, refused} one cycle after the request is taken
  task automatic rq(input frp_pkg::frp_op_t op, input logic [19:0] a, input logic [1:0] e);
    req = '{1'b1, ser, op, a};
    @(negedge clk);
    req.valid = 1'b0;
    chk({go, refd}, e);
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] d, input logic b);
    adr = CA;
    wd = d;
    bop = b;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    bop = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [1:0] s);
    adr = a;
    sz = s;
    crd = 1'b1;
    @(negedge clk);
    crd = 1'b0;
    sz = 2'h0;
    v = {err, rdata};
    cyc(1);
  endtask
  task automatic fetch(input logic [19:0] a, input logic [1:0] e);
    adr = a;
    cfe = 1'b1;
    @(negedge clk);
    cfe = 1'b0;
    chk({err, fok}, e);
  endtask
  task automatic sset(input logic [2:0] b);
    sb = frp_pkg::frp_sec_t'(b);
    ss = 1'b1;
    @(negedge clk);
    ss = 1'b0;
    cyc(2);
  endtask
  task automatic release_wp();
    rel = 1'b1;
    @(negedge clk);
    rel = 1'b0;
    cyc(2);
  endtask
  task automatic win(input logic [7:0] s, input logic [7:0] e, input logic q);
    wst = s;
    wen = e;
    wss = q;
    ws = 1'b1;
    @(negedge clk);
    ws = 1'b0;
    cyc(2);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, ser, slow, ws, wss, ss, rel, cb, db, cwr, crd, cfe, bop, stp} = '0;
    {wst, wen, wd, adr, sz, bp} = '0;
    sb = '0;
    req = '0;
    rst();
    chk(sec, 3'h0);
    chk({owst, owen}, 16'h00ff);
    rd(CA, 2'h0);
    chk(v, 9'h000);
    chk(dfok, 1'b0);
    sset(3'b010);
    cb = 1'b1;
    db = 1'b1;
    release_wp();
    chk(sec, 3'b010);
    rst();
    chk(sec, 3'b010);
    db = 1'b0;
    release_wp();
    chk(sec, 3'b010);
    db = 1'b1;
    release_wp();
    chk(sec, 3'h0);
    win(8'h04, 8'h06, 1'b0);
    chk({owst, owen}, 16'h00ff);
    win(8'h04, 8'h06, 1'b1);
    chk({owst, owen}, 16'h0406);
    rq(OP_W, 20'h0_0c00, 2'b01);
    rq(OP_E, 20'h0_1800, 2'b10);
    rq(OP_W, 20'h0_1c00, 2'b01);
    chk(cmd.addr, 20'h0_1800);
    mode(1'b1);
    rq(OP_W, 20'h0_0400, 2'b10);
    rq(OP_E, 20'h0_3c00, 2'b10);
    sset(3'b001);
    chk(sec, 3'b001);
    rq(OP_E, 20'h0_0fff, 2'b01);
    rq(OP_W, 20'h0_1000, 2'b10);
    win(8'h00, 8'h06, 1'b1);
    mode(1'b0);
    rq(OP_W, 20'h0_0800, 2'b01);
    sset(3'b100);
    chk(sec, 3'b101);
    rq(OP_E, 20'h0_1400, 2'b10);
    mode(1'b1);
    rq(OP_E, 20'h0_2000, 2'b01);
    rq(OP_W, 20'h0_2000, 2'b10);
    sset(3'b010);
    chk(sec, 3'b111);
    rq(OP_W, 20'h0_2000, 2'b01);
    mode(1'b0);
    rq(OP_W, 20'h0_1400, 2'b10);
    cb = 1'b1;
    db = 1'b1;
    release_wp();
    chk(sec, 3'b111);
    rst();
    chk(sec, 3'b111);
    release_wp();
    chk(sec, 3'b111);
    win(8'h04, 8'h06, 1'b1);
    rq(OP_W, 20'hf_1000, 2'b01);
    wr(8'h01, 1'b0);
    rd(CA, 2'h0);
    chk(v, 9'h001);
    rd(20'hf_1000, 2'h0);
    chk(v[8], 1'b1);
    cyc(1150);
    chk(dfok, 1'b0);
    cyc(150);
    chk(dfok, 1'b1);
    wr(8'hff, 1'b0);
    rd(CA, 2'h0);
    chk(v, 9'h001);
    wr(8'h00, 1'b1);
    rd(CA, 2'h0);
    chk(v, 9'h000);
    bp = 3'h3;
    wr(8'h01, 1'b1);
    rd(CA, 2'h0);
    chk(v, 9'h000);
    bp = 3'h0;
    cyc(2);
    chk(dfok, 1'b0);
    slow = 1'b1;
    cyc(3);
    wr(8'h01, 1'b0);
    cyc(170);
    chk(dfok, 1'b0);
    cyc(20);
    chk(dfok, 1'b1);
    rd(20'hf_17ff, 2'h0);
    chk(v, 9'h000);
    rd(20'hf_1000, 2'h1);
    chk(v[8], 1'b1);
    fetch(20'hf_1000, 2'b10);
    rq(OP_E, 20'hf_1234, 2'b10);
    chk({cmd.op, cmd.addr}, {OP_E, 20'hf_1000});
    fetch(20'h0_0100, 2'b01);
    wr(8'h00, 1'b0);
    rd(CA, 2'h0);
    chk(v, 9'h001);
    stp = 1'b1;
    cyc(2);
    chk(sg, 1'b0);
    cyc(25);
    chk(sg, 1'b1);
    stp = 1'b0;
    rq(OP_W, 20'h0_1400, 2'b10);
    rd(20'hf_1000, 2'h0);
    chk(v[8], 1'b1);
    report_and_stop();
  end
endmodule
